// ### hdl/bpc_ctrl.sv
/*
  Controlling-unit end of the backplane: runs memory and I/O cycles,
  answers input requests, ranks interrupts, drives power and clear lines.
  Assumes the board pulls each line high and a low output wins (oe=1).
*/
`timescale 1ns/1ps
module bpc_ctrl #(
  parameter int TMO_CYC_P = bpc_pkg::TMO_CYC
)(
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire bpc_pkg::bpc_bus_i_t    bus_i,
  output bpc_pkg::bpc_bus_oe_t        bus_oe,
  output logic                        od_n,
  output logic [bpc_pkg::AD_W-1:0]    ad_o_n,
  output logic                        ad_oe,
  input  wire logic                   req_v,
  input  wire bpc_pkg::bpc_req_t      req,
  output logic                        busy,
  output logic                        done,
  output logic                        fault,
  output logic [bpc_pkg::AD_W-1:0]    rdata,
  output logic                        in_valid,
  output logic [bpc_pkg::AD_W-1:0]    in_data,
  output logic                        irq_any,
  output logic [3:0]                  irq_top,
  output logic                        dma_pend,
  output logic                        perr,
  input  wire logic                   mclr_req,
  input  wire logic                   pwr_inhibit,
  input  wire logic                   resume_req,
  input  wire logic                   blank_req
);
  import bpc_pkg::*;

  bpc_bus_i_t s1;
  bpc_bus_i_t s2;
  bpc_state_t st;
  bpc_req_t   cyc;
  logic [15:0] cnt;
  logic apr, dap, ioxe, memf, inack, berr;
  logic mclr, minh, resume, blank, perr_d;
  logic [3:0] next_irq;
  logic mc, rdy, flt, in_rq, rst, tmo;

  ////////////////////////////////////////////////////////////////////////
  // Every backplane input is foreign; two stages before any use
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s1 <= '1;
      s2 <= '1;
    end
    else
    begin
      s1 <= bus_i;
      s2 <= s1;
    end
  end

  assign mc    = !s2.master_clear_n;   // see RL1
  assign rdy   = !s2.data_ready_n;
  assign flt   = !s2.bus_fault_n;
  assign in_rq = !s2.input_request_n;
  // Bus master clear initialises the sequencer and line state, but not the input synchronisers or our own clear driver
  assign rst   = sys_rst | mc;         // see RL11
  assign tmo   = cnt == 16'(TMO_CYC_P - 1);

  // Open-collector: value is always low, the enable does the asserting
  assign bus_oe = '{apr, dap, ioxe, memf, inack, berr,
                    mclr, minh, resume, blank};  // see RL22

  always_ff @(posedge core_clk)
  begin
    od_n <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st       <= S_IDLE;
      cyc      <= '0;
      cnt      <= '0;
      apr      <= 1'b0;
      dap      <= 1'b0;
      ioxe     <= 1'b0;
      memf     <= 1'b0;
      inack    <= 1'b0;
      berr     <= 1'b0;
      ad_oe    <= 1'b0;
      ad_o_n   <= '1;
      busy     <= 1'b0;
      done     <= 1'b0;
      fault    <= 1'b0;
      rdata    <= '0;
      in_valid <= 1'b0;
      in_data  <= '0;
    end
    else
    begin
      done     <= 1'b0;
      in_valid <= 1'b0;
      berr     <= 1'b0;
      unique case (st)
        S_IDLE:
        begin
          // A stuck data-ready from the last answer blocks a new cycle
          if (req_v && !rdy)
          begin
            if (req.mem && minh)
            begin
              done  <= 1'b1;           // see RL13
              fault <= 1'b1;
            end
            else
            begin
              cyc    <= req;
              ad_o_n <= ~req.addr;     // see RL2
              ad_oe  <= 1'b1;
              apr    <= 1'b1;          // see RL3
              memf   <= req.mem;       // see RL12
              fault  <= 1'b0;
              cnt    <= 16'(ADDR_CYC - 1);
              busy   <= 1'b1;
              st     <= S_ADDR;
            end
          end
          else if (in_rq && !rdy)
          begin
            inack <= 1'b1;             // see RL6
            cnt   <= '0;
            fault <= 1'b0;
            busy  <= 1'b1;
            st    <= S_ACK;
          end
        end
        S_ADDR:
        begin
          if (cnt == '0)
          begin
            apr    <= 1'b0;
            ad_o_n <= ~cyc.wdata;
            ad_oe  <= cyc.wr;
            dap    <= cyc.mem && cyc.wr;   // see RL9
            ioxe   <= !cyc.mem;            // see RL10
            st     <= S_WAIT;
          end
          else
          begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_WAIT:
        begin
          // Answer, a fault from any unit, or no answer at all ends it
          if (rdy || flt || tmo)
          begin
            if (!cyc.wr)
            begin
              rdata <= ~s2.ad_n;       // see RL4
            end
            fault <= !rdy;
            berr  <= !rdy && !flt;     // see RL5
            ad_oe <= 1'b0;
            dap   <= 1'b0;
            ioxe  <= 1'b0;
            memf  <= 1'b0;
            done  <= 1'b1;
            st    <= S_REL;
          end
          else
          begin
            cnt <= cnt + 16'h0001;
          end
        end
        S_ACK:
        begin
          if (rdy || tmo)
          begin
            in_data  <= ~s2.ad_n;      // see RL7
            in_valid <= rdy;
            fault    <= !rdy;
            berr     <= !rdy;          // see RL5
            inack    <= 1'b0;
            st       <= S_REL;
          end
          else
          begin
            cnt <= cnt + 16'h0001;
          end
        end
        S_REL:
        begin
          // Limitation: a data-ready held forever stalls here
          if (!rdy)
          begin
            busy <= 1'b0;
            st   <= S_IDLE;
          end
        end
        default:
        begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt ranking: later index wins, so the top level takes it
  always_comb
  begin
    next_irq = '0;
    for (int i = 0; i < IRQ_N; i++)
    begin
      if (!s2.irq_levels_n[i])
      begin
        next_irq = (i == IRQ_N - 1) ? IRQ_TOP
                                    : IRQ_BASE + 4'(i);  // see RL8
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_any  <= 1'b0;
      irq_top  <= '0;
      dma_pend <= 1'b0;
      perr     <= 1'b0;
      perr_d   <= 1'b0;
      minh     <= 1'b0;
      resume   <= 1'b0;
      blank    <= 1'b0;
    end
    else
    begin
      irq_any  <= !(&s2.irq_levels_n);
      irq_top  <= next_irq;
      dma_pend <= !s2.dma_request_n;
      perr_d   <= !s2.parity_n;
      perr     <= !s2.parity_n && !perr_d;   // see RL14
      minh     <= pwr_inhibit;               // see RL13
      resume   <= resume_req;                // see RL18
      blank    <= blank_req;                 // see RL19
    end
  end

  // Own clear driver must survive the clear it causes
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mclr <= 1'b0;
    end
    else
    begin
      mclr <= mclr_req;                      // see RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ack_no_addr_a: assert property (  // see RL6
    @(posedge core_clk) disable iff (rst)
    inack |-> !apr && !ad_oe)
    else $error("input ack overlaps an address phase");

  io_strobe_a: assert property (  // see RL10
    @(posedge core_clk) disable iff (rst)
    (st == S_ADDR && cnt == '0 && !cyc.mem) |=> ioxe && !memf)
    else $error("io strobe missing on io cycle");

  mem_flag_a: assert property (  // see RL12
    @(posedge core_clk) disable iff (rst)
    (st == S_IDLE && req_v && !rdy && !minh) |=> memf == $past(req.mem))
    else $error("memory flag wrong for cycle");

  inhibit_refuse_a: assert property (  // see RL13
    @(posedge core_clk) disable iff (rst)
    (st == S_IDLE && req_v && req.mem && minh && !rdy)
      |=> st == S_IDLE && done && fault && !apr)
    else $error("memory access taken while inhibited");

  addr_phase_a: assert property (  // see RL3
    @(posedge core_clk) disable iff (rst)
    $rose(apr) |-> ad_oe ##1 apr [*1] ##1 !apr)
    else $error("address present not held for the address phase");

  timeout_a: assert property (  // see RL5
    @(posedge core_clk) disable iff (rst)
    (st == S_WAIT && tmo && !rdy && !flt) |=> berr && fault && done)
    else $error("no bus fault after answer timeout");

  irq_rank_a: assert property (  // see RL8
    @(posedge core_clk) disable iff (rst)
    !s2.irq_levels_n[IRQ_N-1] |=> irq_top == 4'hF && irq_any)
    else $error("top interrupt level not ranked first");

  parity_pulse_a: assert property (  // see RL14
    @(posedge core_clk) disable iff (rst)
    $fell(s2.parity_n) |=> perr ##1 !perr)
    else $error("parity report not a single pulse");

  clear_init_a: assert property (  // see RL11
    @(posedge core_clk) disable iff (sys_rst)
    mc |=> st == S_IDLE && !apr && !inack && !busy)
    else $error("master clear did not initialise the sequencer");
endmodule // bpc_ctrl

// ### hdl/bpc_pkg.sv
/*
  Constants, carrier types and states for the backplane controlling-unit
  end. Assumes a single 40 MHz core clock and active-low backplane lines.
*/
// Function
// RL1 - Lines assert low, negate high
// RL2 - Shared 24-bit address/data lines, bit 0 LSB
// RL3 - Address-present held while address is driven
// RL4 - Answering unit asserts data-ready
// RL5 - Detected bus-cycle error asserts bus fault
// RL6 - Controller grants input request with input acknowledge
// RL7 - Interface waits for acknowledge before driving data
// RL8 - Interrupt levels 10-13, 15; higher ranks first
// RL9 - Data-present marks valid data in memory cycles
// RL10 - Controller strobes every I/O data transfer; code strobes I/O cycles only, not input-request transfers
// RL11 - Master clear initialises card logic
// RL12 - Memory-cycle flag set for memory cycles
// RL13 - Memory inhibit refuses memory accesses
// RL14 - Parity line reports memory fatal/correctable error
// RL15 - Interface asserts DMA request for DMA cycle
// RL16 - Control request line, future extensions only
// RL17 - Idle unit passes control chain onward
// RL18 - Resume line restarts a stopped processor
// RL19 - Output suppress blanks process interface outputs
// RL20 - Early DMA requester uses grant, else forwards
// RL21 - Early interrupter sends identity, else passes chain
// RL22 - Wired-OR lines driven open-collector style
package bpc_pkg;
  localparam int AD_W      = 24;
  localparam int IRQ_N     = 5;
  localparam int CLK_NS    = 25;
  localparam int T_ADDR_NS = 50;
  localparam int ADDR_CYC  = (T_ADDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_TMO_NS  = 10000;
  localparam int TMO_CYC   = T_TMO_NS / CLK_NS;
  localparam logic [3:0] IRQ_BASE = 4'hA;
  localparam logic [3:0] IRQ_TOP  = 4'hF;

  typedef struct packed {
    logic [AD_W-1:0]  ad_n;
    logic             addr_present_n;
    logic             data_ready_n;
    logic             bus_fault_n;
    logic             input_request_n;
    logic [IRQ_N-1:0] irq_levels_n;
    logic             master_clear_n;
    logic             parity_n;
    logic             dma_request_n;
  } bpc_bus_i_t;

  typedef struct packed {
    logic addr_present;
    logic data_present;
    logic io_enable_strobe;
    logic memory_cycle_flag;
    logic input_ack;
    logic bus_fault;
    logic master_clear;
    logic memory_inhibit;
    logic resume;
    logic output_suppress;
  } bpc_bus_oe_t;

  typedef struct packed {
    logic            mem;
    logic            wr;
    logic [AD_W-1:0] addr;
    logic [AD_W-1:0] wdata;
  } bpc_req_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ADDR = 5'h02,
    S_WAIT = 5'h04,
    S_ACK  = 5'h08,
    S_REL  = 5'h10
  } bpc_state_t;
endpackage

// ### tb/bpc_far.sv
/*
  Far-side card model: answers controller cycles and raises input
  requests. Assumes pulled-up lines, so a released line reads 1.
*/
`timescale 1ns/1ps
module bpc_far (
  input  wire logic                 core_clk,
  input  wire bpc_pkg::bpc_bus_oe_t bus_oe,
  input  wire logic                 ad_oe,
  input  wire logic [3:0]           dly,
  input  wire logic                 mute,
  input  wire logic                 in_want,
  input  wire logic [23:0]          rd_val,
  input  wire logic [2:0]           chain_in,
  output logic                      dr_n,
  output logic                      irn,
  output logic                      ad_en,
  output logic [23:0]               ad_val_n,
  output logic [2:0]                chain_out,
  output logic                      crq_n
);
  import bpc_pkg::*;
  logic       seen = 1'b0;
  logic       ackd = 1'b0;
  logic       rdy  = 1'b0;
  logic [3:0] cnt  = 4'h0;
  wire        go;
  assign go = (seen & ~bus_oe.addr_present & (bus_oe.io_enable_strobe
              | bus_oe.memory_cycle_flag | bus_oe.data_present))
              | bus_oe.input_ack;
  //////////////////////////////////////////////////////////////////////
  // Mute leaves the cycle unanswered so the timeout path is reachable
  always_ff @(posedge core_clk)
  begin
    if (bus_oe.addr_present)
      seen <= 1'b1;
    if (go)
      cnt <= cnt + 4'h1;
    if (go && cnt == dly && !mute)
      rdy <= 1'b1;
    if (!go)
    begin
      cnt  <= 4'h0;
      rdy  <= 1'b0;
      seen <= bus_oe.addr_present;
    end
    ackd <= in_want & (ackd | bus_oe.input_ack);
  end
  assign dr_n     = ~rdy;
  assign irn      = ~(in_want & ~ackd);
  assign ad_en    = rdy & ~ad_oe;
  assign ad_val_n = ~rd_val;
  // Card never wants control, DMA or identity service: it keeps the
  // reserved request idle and hands each chain straight on
  assign crq_n        = 1'b1;
  assign chain_out[0] = chain_in[0];
  assign chain_out[1] = chain_in[1];
  assign chain_out[2] = chain_in[2];
endmodule // bpc_far

// ### tb/tb_bpc_ctrl.sv
/*
  Self-checking bench for the controlling-unit end: bus cycles, input
  transfers, interrupts and line drivers. Assumes pulled-up lines.
*/
`timescale 1ns/1ps
module tb_bpc_ctrl;
  import bpc_pkg::*;
  logic            core_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            req_v, mclr_req, pwr_inhibit, resume_req, blank_req;
  logic            mute, in_want, ext_flt, par_n, dreq_n;
  logic            od_n, ad_oe, busy, done, fault, in_valid, irq_any;
  logic            dma_pend, perr, dr_n, irn, ad_en, crq_n;
  logic [2:0]      chain_in = 3'h5;
  logic [2:0]      chain_out;
  logic [3:0]      dly = 4'h1;
  logic [3:0]      irq_top;
  logic [4:0]      irq_n = 5'h1F;
  logic [AD_W-1:0] ad_o_n, rdata, in_data, ad_val_n;
  logic [AD_W-1:0] rd_val = 24'h00_0000;
  bpc_req_t        req = '0;
  bpc_bus_i_t      bus_i;
  bpc_bus_oe_t     bus_oe;
  int              n_errors = 0;
  int              checks_done = 0;
  int              cyc = 0;
  initial
  begin
    {req_v, mclr_req, pwr_inhibit, resume_req, blank_req} = '0;
    {mute, in_want, ext_flt} = '0;
    {par_n, dreq_n} = 2'h3;
  end
  always_comb
  begin
    bus_i.ad_n = (ad_oe ? ad_o_n : '1) & (ad_en ? ad_val_n : '1);
    bus_i.addr_present_n  = ~bus_oe.addr_present;
    bus_i.data_ready_n    = dr_n;
    bus_i.bus_fault_n     = ~(bus_oe.bus_fault | ext_flt);
    bus_i.input_request_n = irn;
    bus_i.irq_levels_n    = irq_n;
    bus_i.master_clear_n  = ~bus_oe.master_clear;
    bus_i.parity_n        = par_n;
    bus_i.dma_request_n   = dreq_n;
  end
  bpc_ctrl #(.TMO_CYC_P(20)) u_bpc_ctrl (.core_clk, .sys_rst, .bus_i,
    .bus_oe, .od_n, .ad_o_n, .ad_oe, .req_v, .req, .busy, .done, .fault,
    .rdata, .in_valid, .in_data, .irq_any, .irq_top, .dma_pend, .perr,
    .mclr_req, .pwr_inhibit, .resume_req, .blank_req);
  bpc_far u_bpc_far (.core_clk, .bus_oe, .ad_oe, .dly, .mute, .in_want,
    .rd_val, .chain_in, .dr_n, .irn, .ad_en, .ad_val_n, .chain_out, .crq_n);
  initial
    forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [AD_W-1:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Flags: address on lines, memory flag, I/O strobe, own write data
  task automatic run_cyc(input logic mem, wr, input logic [AD_W-1:0] a, d,
                         output logic [3:0] s);
    s = 4'h0;
    req = '{mem, wr, a, d};
    req_v = 1'b1;
    @(negedge core_clk);
    req_v = 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++)
    begin
      @(negedge core_clk);
      s[0] |= !bus_i.addr_present_n && bus_i.ad_n === ~a;
      s[1] |= bus_oe.memory_cycle_flag;
      s[2] |= bus_oe.io_enable_strobe;
      s[3] |= (bus_oe.data_present | bus_oe.io_enable_strobe) && ad_oe
              && bus_i.ad_n === ~d;
    end
    chk("done", 1, done);
    for (int i = 0; i < 30 && busy !== 1'b0; i++)
      @(negedge core_clk);
  endtask
  task automatic t_cycles;
    logic [3:0] s;
    run_cyc(1'b1, 1'b1, 24'h80_0003, 24'h12_3456, s);
    chk("mem wr", 4'hB, s);
    dly = 4'h5;
    rd_val = 24'hA5_5A3C;
    run_cyc(1'b0, 1'b0, 24'h00_0041, 24'h00_0000, s);
    chk("io rd", 4'h5, s);
    chk("io rdata", rd_val, rdata);
    dly = 4'h2;
    rd_val = 24'h0F_F0C3;
    run_cyc(1'b1, 1'b0, 24'hFF_FFFF, 24'h00_0000, s);
    chk("mem rdata", rd_val, rdata);
    chk("mem fault", 0, fault);
  endtask
  task automatic t_faults;
    logic [3:0] s;
    int         c0;
    pwr_inhibit = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("inhibit oe", 1, bus_oe.memory_inhibit);
    run_cyc(1'b1, 1'b1, 24'h00_0010, 24'h00_0001, s);
    chk("inh lines", 0, s);
    chk("inh fault", 1, fault);
    pwr_inhibit = 1'b0;
    mute = 1'b1;
    run_cyc(1'b0, 1'b1, 24'h00_0020, 24'h00_0002, s);
    chk("tmo fault", 1, fault);
    c0 = cyc;
    fork
      run_cyc(1'b0, 1'b1, 24'h00_0030, 24'h00_0003, s);
      begin
        repeat (6) @(negedge core_clk);
        ext_flt = 1'b1;
      end
    join
    ext_flt = 1'b0;
    mute = 1'b0;
    chk("ext fault", 1, fault);
    chk("ext early", 1, (cyc - c0) < 16);
  endtask
  task automatic t_input;
    logic bseen = 1'b0;
    in_want = 1'b1;
    rd_val = 24'h3C_0F81;
    for (int i = 0; i < 40 && in_valid !== 1'b1; i++)
      @(negedge core_clk);
    chk("in data", rd_val, in_data);
    in_want = 1'b0;
    for (int i = 0; i < 30 && busy !== 1'b0; i++)
      @(negedge core_clk);
    chk("in busy", 0, busy);
    // Unanswered input transfer must end by itself with a fault pulse
    mute = 1'b1;
    in_want = 1'b1;
    repeat (30)
    begin
      @(negedge core_clk);
      bseen |= bus_oe.bus_fault;
    end
    chk("in tmo", 1, fault);
    chk("in tmo pulse", 1, bseen);
    in_want = 1'b0;
    mute = 1'b0;
  endtask
  // Single levels, then pairs where the higher must win
  task automatic t_irq;
    logic [4:0] pat [7] = '{5'h1E, 5'h1D, 5'h1B, 5'h17, 5'h0F,
                            5'h16, 5'h0E};
    logic [3:0] top [7] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'hD, 4'hF};
    for (int i = 0; i < 7; i++)
    begin
      irq_n = pat[i];
      repeat (3) @(negedge core_clk);
      chk("irq top", top[i], irq_top);
    end
    irq_n = 5'h1F;
    repeat (3) @(negedge core_clk);
    chk("irq none", 0, irq_any);
  endtask
  task automatic t_lines;
    logic pseen = 1'b0;
    {blank_req, resume_req, dreq_n, par_n} = 4'hC;
    @(negedge core_clk);
    par_n = 1'b1;
    chk("blank", 1, bus_oe.output_suppress);
    chk("resume", 1, bus_oe.resume);
    repeat (3)
    begin
      @(negedge core_clk);
      pseen |= perr;
    end
    chk("parity", 1, pseen);
    chk("dma", 1, dma_pend);
    chk("od level", 0, od_n);
    chk("crq idle", 1, crq_n);
    chk("chains", chain_in, chain_out);
    // Clear must kill a cycle that is still hanging on the bus
    mute = 1'b1;
    req = '{1'b0, 1'b1, 24'h00_0050, 24'h00_0005};
    req_v = 1'b1;
    @(negedge core_clk);
    req_v = 1'b0;
    {blank_req, resume_req, dreq_n, mclr_req} = 4'h3;
    @(negedge core_clk);
    chk("mclr oe", 1, bus_oe.master_clear);
    chk("mclr hang", 1, busy);
    repeat (3) @(negedge core_clk);
    chk("mclr busy", 0, busy);
    mclr_req = 1'b0;
    mute = 1'b0;
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_cycles();
    t_faults();
    t_input();
    t_irq();
    t_lines();
    print_verdict();
  end
endmodule // tb_bpc_ctrl
